/* File: rtl/dva_arbiter.sv */
`timescale 1ns/100ps
module dva_arbiter
	import dva_pkg::*;
#(
	parameter int unsigned NUM_BANKS = 4,
	parameter int unsigned BANK_W    = 2
)(
	input  wire logic                 clk_sys_i,
	input  wire logic                 rst_n_i,
	input  wire logic                 port_a_chip_select_n_i,
	input  wire logic                 port_a_address_strobe_n_i,
	input  wire logic                 port_a_access_request_n_i,
	input  wire logic                 port_b_access_request_n_i,
	input  wire logic                 lock_n_i,
	input  wire logic                 refresh_request_i,
	input  wire logic [BANK_W-1:0]    bank_select_i,
	input  wire logic                 column_strobe_enable_n_i,
	input  wire logic                 column_hold_option_i,
	input  wire logic                 precharge_select_low_i,
	input  wire logic                 precharge_select_high_i,
	output logic                      port_b_granted_o,
	output logic [NUM_BANKS-1:0]      row_strobe_n_o,
	output logic                      column_strobe_n_o,
	output logic                      port_b_advance_ack_n_o,
	output logic                      port_a_wait_n_o,
	output logic                      refresh_active_o
);

	logic                 a_req;
	logic                 b_req;
	logic                 lock;
	logic                 busy;
	logic                 grant_hold;
	logic                 settled;
	logic                 grant_b;
	logic [1:0]           psel;
	logic                 bank_ready;
	logic                 all_ready;
	logic                 start_ref;
	logic                 start_a;
	logic                 start_b;
	logic [NUM_BANKS-1:0] prech_done;
	logic [NUM_BANKS-1:0] prech_start;
	dva_cnt_t             prech_load;

	dva_state_e           state_r;
	dva_state_e           state_nxt;
	logic [BANK_W-1:0]    bank_r;
	logic [BANK_W-1:0]    bank_nxt;
	dva_cnt_t             ref_cnt_r;
	dva_cnt_t             ref_cnt_nxt;

	logic [NUM_BANKS-1:0] ras_n_r;
	logic [NUM_BANKS-1:0] ras_n_nxt;
	logic                 col_n_r;
	logic                 col_n_nxt;
	logic                 ack_n_r;
	logic                 ack_n_nxt;
	logic                 wait_n_r;
	logic                 wait_n_nxt;
	logic                 ref_act_r;
	logic                 ref_act_nxt;

	// No synchroniser here: every request is sampled as already clock-aligned.
	assign a_req = !port_a_chip_select_n_i &&
		(!port_a_address_strobe_n_i || !port_a_access_request_n_i);
	assign b_req      = !port_b_access_request_n_i;
	assign lock       = !lock_n_i;
	assign psel       = {precharge_select_high_i, precharge_select_low_i};
	assign busy       = (state_r == ST_ACC_A) || (state_r == ST_ACC_B);
	assign prech_load = dva_prech_load(psel);
	assign bank_ready = prech_done[bank_select_i];
	assign all_ready  = &prech_done;

	// Refresh also freezes the grant, so a grant change never lands on a refresh edge.
	assign grant_hold = (state_r != ST_IDLE) || refresh_request_i;

	// Refresh is checked ahead of both ports, and the grant picks which port may go.
	assign start_ref = refresh_request_i && all_ready;
	assign start_a   = (grant_b == GNT_PORT_A) && a_req && settled && bank_ready &&
		!refresh_request_i;
	assign start_b   = (grant_b == GNT_PORT_B) && b_req && settled && bank_ready &&
		!refresh_request_i;

	generate
		if (NUM_BANKS != (1 << BANK_W))
		begin : g_bad_banks
			$error("NUM_BANKS must equal two to the power BANK_W");
		end
		for (genvar i = 0; i < NUM_BANKS; i++)
		begin : g_bank
			dva_prech_timer u_timer (
				.clk_sys_i (clk_sys_i),
				.rst_n_i   (rst_n_i),
				.start_i   (prech_start[i]),
				.load_i    (prech_load),
				.done_o    (prech_done[i])
			);
		end
	endgenerate

	dva_grant_unit u_grant (
		.clk_sys_i   (clk_sys_i),
		.rst_n_i     (rst_n_i),
		.a_req_i     (a_req),
		.b_req_i     (b_req),
		.lock_i      (lock),
		.busy_i      (grant_hold),
		.wait_load_i (dva_gnt_wait(psel)),
		.grant_b_o   (grant_b),
		.settled_o   (settled)
	);

	always_comb
	begin
		state_nxt   = state_r;
		bank_nxt    = bank_r;
		ref_cnt_nxt = ref_cnt_r;
		prech_start = '0;
		unique case (state_r)
			ST_IDLE:
			begin
				if (start_ref)
				begin
					state_nxt   = ST_REFRESH;
					ref_cnt_nxt = dva_ref_load(psel);
				end
				else if (start_a)
				begin
					state_nxt = ST_ACC_A;
					bank_nxt  = bank_select_i;
				end
				else if (start_b)
				begin
					state_nxt = ST_ACC_B;
					bank_nxt  = bank_select_i;
				end
			end
			ST_ACC_A:
			begin
				if (!a_req)
				begin
					state_nxt           = ST_IDLE;
					prech_start[bank_r] = 1'b1;
				end
			end
			ST_ACC_B:
			begin
				if (!b_req)
				begin
					state_nxt           = ST_IDLE;
					prech_start[bank_r] = 1'b1;
				end
			end
			ST_REFRESH:
			begin
				if (ref_cnt_r == '0)
				begin
					state_nxt   = ST_IDLE;
					prech_start = '1;
				end
				else
					ref_cnt_nxt = ref_cnt_r - CNT_ONE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			state_r   <= ST_IDLE;
			bank_r    <= '0;
			ref_cnt_r <= '0;
		end
		else
		begin
			state_r   <= state_nxt;
			bank_r    <= bank_nxt;
			ref_cnt_r <= ref_cnt_nxt;
		end
	end

	always_comb
	begin
		ras_n_nxt = '1;
		if (state_nxt == ST_REFRESH)
			ras_n_nxt = '0;
		else if (state_nxt == ST_ACC_A || state_nxt == ST_ACC_B)
			ras_n_nxt[bank_nxt] = 1'b0;
		// Column strobe trails the row strobe by one clock to give the address time to turn.
		col_n_nxt = !((busy && state_nxt == state_r && !column_strobe_enable_n_i) ||
			(column_hold_option_i && !col_n_r && !column_strobe_enable_n_i));
		ack_n_nxt   = !(state_nxt == ST_ACC_B);
		wait_n_nxt  = !(a_req && state_nxt != ST_ACC_A);
		ref_act_nxt = (state_nxt == ST_REFRESH);
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			ras_n_r   <= '1;
			col_n_r   <= 1'b1;
			ack_n_r   <= 1'b1;
			wait_n_r  <= 1'b1;
			ref_act_r <= 1'b0;
		end
		else
		begin
			ras_n_r   <= ras_n_nxt;
			col_n_r   <= col_n_nxt;
			ack_n_r   <= ack_n_nxt;
			wait_n_r  <= wait_n_nxt;
			ref_act_r <= ref_act_nxt;
		end
	end

	assign port_b_granted_o       = grant_b;
	assign row_strobe_n_o         = ras_n_r;
	assign column_strobe_n_o      = col_n_r;
	assign port_b_advance_ack_n_o = ack_n_r;
	assign port_a_wait_n_o        = wait_n_r;
	assign refresh_active_o       = ref_act_r;

	default clocking cb @(posedge clk_sys_i);
	endclocking

	default disable iff (!rst_n_i);

	a_refresh_first: assert property (
		(state_r == ST_IDLE && start_ref) |=> (refresh_active_o && row_strobe_n_o == '0)
	) else $error("refresh did not win the array");

	a_grant_stays: assert property (
		(!busy && !b_req && port_b_granted_o == GNT_PORT_A) |=> !port_b_granted_o
	) else $error("grant left port A without a port B request");

	a_grant_to_b_cause: assert property (
		$rose(port_b_granted_o) |-> $past(b_req && !a_req && !lock && !busy)
	) else $error("grant moved to port B without cause");

	a_b_fast_start: assert property (
		(state_r == ST_IDLE && start_b && !start_ref)
		|=> (!row_strobe_n_o[$past(bank_select_i)] && !port_b_advance_ack_n_o)
	) else $error("granted port B did not get the row strobe next edge");

	a_b_ras_release: assert property (
		(state_r == ST_ACC_B && !b_req) |=> (row_strobe_n_o == '1 && port_b_advance_ack_n_o)
	) else $error("row strobe stayed after port B request negated");

	a_col_hold: assert property (
		(column_hold_option_i && !column_strobe_n_o && !column_strobe_enable_n_i)
		|=> !column_strobe_n_o
	) else $error("column strobe dropped while held");

	a_b_second_edge: assert property (
		($rose(port_b_granted_o) && psel[0])
		|-> ##1 (port_b_advance_ack_n_o && (row_strobe_n_o == '1 || refresh_active_o))
	) else $error("port B started before the second edge");

	a_b_after_grant: assert property (
		$rose(port_b_granted_o) |-> (row_strobe_n_o == '1 && port_b_advance_ack_n_o)
	) else $error("port B access began before the grant moved");

	a_a_decode: assert property (
		(state_r == ST_IDLE && start_a && !start_ref) |=> (state_r == ST_ACC_A && port_a_wait_n_o)
	) else $error("port A request not taken");

	a_a_keeps_grant: assert property (
		(!port_b_granted_o && a_req) |=> !port_b_granted_o
	) else $error("grant left port A while it requested");

	a_ack_with_ras: assert property (
		$fell(port_b_advance_ack_n_o) |-> (state_r == ST_ACC_B && !row_strobe_n_o[bank_r])
	) else $error("acknowledge without port B row strobe");

	a_ack_until_release: assert property (
		(!port_b_advance_ack_n_o && b_req) |=> !port_b_advance_ack_n_o
	) else $error("acknowledge dropped before port B request negated");

	a_lock_holds: assert property (
		lock |=> $stable(port_b_granted_o)
	) else $error("grant changed while locked");

	a_grant_before_ras: assert property (
		$changed(port_b_granted_o) |-> (row_strobe_n_o == '1)
	) else $error("grant changed during a row strobe");

	a_reset_state: assert property (
		@(posedge clk_sys_i) disable iff (1'b0)
		$past(!rst_n_i) |-> (!port_b_granted_o && port_b_advance_ack_n_o && &row_strobe_n_o)
	) else $error("outputs not at reset values");

	c_b_access: cover property (state_r == ST_IDLE ##1 state_r == ST_ACC_B);
	c_grant_to_b: cover property ($rose(port_b_granted_o) ##[1:2] !port_b_advance_ack_n_o);
	c_refresh: cover property ($rose(refresh_active_o));
	c_col_held: cover property ($rose(row_strobe_n_o[0]) && !column_strobe_n_o);

endmodule

/* File: rtl/dva_grant_unit.sv */
`timescale 1ns/100ps
module dva_grant_unit
	import dva_pkg::*;
(
	input  wire logic     clk_sys_i,
	input  wire logic     rst_n_i,
	input  wire logic     a_req_i,
	input  wire logic     b_req_i,
	input  wire logic     lock_i,
	input  wire logic     busy_i,
	input  wire dva_cnt_t wait_load_i,
	output logic          grant_b_o,
	output logic          settled_o
);

	logic     grant_r;
	logic     grant_nxt;
	dva_cnt_t wait_r;
	dva_cnt_t wait_nxt;

	always_comb
	begin
		grant_nxt = grant_r;
		wait_nxt  = (wait_r != '0) ? wait_r - CNT_ONE : wait_r;
		// A held lock or a running access pins the grant to the current owner.
		if (!busy_i && !lock_i)
		begin
			if (grant_r == GNT_PORT_A && !a_req_i && b_req_i)
			begin
				grant_nxt = GNT_PORT_B;
				wait_nxt  = wait_load_i;
			end
			else if (grant_r == GNT_PORT_B && !b_req_i && a_req_i)
			begin
				grant_nxt = GNT_PORT_A;
				wait_nxt  = wait_load_i;
			end
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			grant_r <= GNT_PORT_A;
			wait_r  <= '0;
		end
		else
		begin
			grant_r <= grant_nxt;
			wait_r  <= wait_nxt;
		end
	end

	assign grant_b_o = grant_r;
	assign settled_o = (wait_r == '0);

endmodule

/* File: rtl/dva_pkg.sv */
package dva_pkg;

	// Width of the small edge counters used for precharge, refresh and grant settling.
	localparam int unsigned CNT_W = 2;

	typedef logic [CNT_W-1:0] dva_cnt_t;

	// Precharge-select codes, high bit first.
	localparam logic [1:0] PSEL_FAST  = 2'h0;
	localparam logic [1:0] PSEL_SLOW  = 2'h1;
	localparam logic [1:0] PSEL_MIXED = 2'h2;
	localparam logic [1:0] PSEL_LONG  = 2'h3;

	localparam dva_cnt_t PRE_EDGES_SHORT = 2'h1;
	localparam dva_cnt_t PRE_EDGES_LONG  = 2'h2;
	localparam dva_cnt_t REF_EDGES_SHORT = 2'h2;
	localparam dva_cnt_t REF_EDGES_LONG  = 2'h3;
	localparam dva_cnt_t GNT_WAIT_FIRST  = 2'h0;
	localparam dva_cnt_t GNT_WAIT_SECOND = 2'h1;
	localparam dva_cnt_t CNT_ONE         = 2'h1;

	localparam logic GNT_PORT_A = 1'b0;
	localparam logic GNT_PORT_B = 1'b1;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_ACC_A   = 2'b01,
		ST_ACC_B   = 2'b10,
		ST_REFRESH = 2'b11
	} dva_state_e;

	// Counters are loaded with edges minus one so that zero means the time has run out.
	function automatic dva_cnt_t dva_prech_load(input logic [1:0] sel);
		return (sel == PSEL_FAST) ? PRE_EDGES_SHORT - CNT_ONE : PRE_EDGES_LONG - CNT_ONE;
	endfunction

	function automatic dva_cnt_t dva_ref_load(input logic [1:0] sel);
		return sel[0] ? REF_EDGES_LONG - CNT_ONE : REF_EDGES_SHORT - CNT_ONE;
	endfunction

	function automatic dva_cnt_t dva_gnt_wait(input logic [1:0] sel);
		return sel[0] ? GNT_WAIT_SECOND : GNT_WAIT_FIRST;
	endfunction

endpackage

/* File: rtl/dva_prech_timer.sv */
`timescale 1ns/100ps
module dva_prech_timer
	import dva_pkg::*;
(
	input  wire logic     clk_sys_i,
	input  wire logic     rst_n_i,
	input  wire logic     start_i,
	input  wire dva_cnt_t load_i,
	output logic          done_o
);

	dva_cnt_t cnt_r;
	dva_cnt_t cnt_nxt;

	always_comb
	begin
		cnt_nxt = cnt_r;
		if (start_i)
			cnt_nxt = load_i;
		else if (cnt_r != '0)
			cnt_nxt = cnt_r - CNT_ONE;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
			cnt_r <= '0;
		else
			cnt_r <= cnt_nxt;
	end

	assign done_o = (cnt_r == '0);

endmodule

/* File: testbench/dva_arbiter_tb_top.sv */
`timescale 1ns/100ps
module dva_arbiter_tb_top;
	logic       clk, rst_n, cs_n, ads_n, port_a_access_request_n, lock_n, rfq, cse_n, psl, psh, go;
	logic       gnt, col, ack_n, rfa, breq_n, bdone, wt_n;
	logic [1:0] bank_a, bank_b, bank;
	logic [3:0] row, row_prev, hold_b;
	logic [7:0] lat;
	logic [3:0] q[$];
	int         n_mismatch, total_checks, cyc, gap, k;

	// Only the granted port's bank reaches the shared input.
	assign bank = gnt ? bank_b : bank_a;

	dva_arbiter DUT
	(
		.clk_sys_i                 (clk),
		.rst_n_i                   (rst_n),
		.port_a_chip_select_n_i    (cs_n),
		.port_a_address_strobe_n_i (ads_n),
		.port_a_access_request_n_i (port_a_access_request_n),
		.port_b_access_request_n_i (breq_n),
		.lock_n_i                  (lock_n),
		.refresh_request_i         (rfq),
		.bank_select_i             (bank),
		.column_strobe_enable_n_i  (cse_n),
		.column_hold_option_i      (1'b1),
		.precharge_select_low_i    (psl),
		.precharge_select_high_i   (psh),
		.port_b_granted_o          (gnt),
		.row_strobe_n_o            (row),
		.column_strobe_n_o         (col),
		.port_b_advance_ack_n_o    (ack_n),
		.port_a_wait_n_o           (wt_n),
		.refresh_active_o          (rfa)
	);

	dva_cpu_b_model cpu_b
	(
		.clk_sys_i (clk),
		.go_i      (go),
		.hold_i    (hold_b),
		.ack_n_i   (ack_n),
		.req_n_o   (breq_n),
		.lat_o     (lat),
		.done_o    (bdone)
	);

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	function automatic logic [1:0] idx(input logic [3:0] r);
		logic [1:0] b;
		b = 2'h0;
		for (int i = 0; i < 4; i++)
			if (r[i] === 1'b0)
				b = 2'(i);
		return b;
	endfunction

	// Each new access start is matched against the oldest note.
	always @(posedge clk)
	begin
		row_prev <= row;
		if (rst_n && rfa !== 1'b1 && row_prev === 4'hf && row !== 4'hf)
		begin
			if (q.size() == 0)
				chk(8'hff, 8'h00);
			else
				chk(8'({gnt, ~ack_n, idx(row)}), 8'(q.pop_front()));
		end
		cyc++;
		if (cyc == 20000)
		begin
			n_mismatch++;
			end_of_test();
		end
	end

	task automatic a_acc(input logic [1:0] bk, input logic [3:0] hd, input logic ads);
		int n;
		int nw;
		q.push_back({2'b00, bk});
		cs_n <= 1'b0;
		ads_n <= ~ads;
		port_a_access_request_n <= ads;
		bank_a <= bk;
		n = 0;
		nw = 0;
		do
		begin
			@(posedge clk);
			n++;
			if (wt_n === 1'b0)
				nw++;
		end
		while (row === 4'hf && n < 40);
		// Port A must be held in wait on every edge that does not yet start its access.
		chk(8'(nw), 8'(n - 2));
		repeat (hd) @(posedge clk);
		{cs_n, ads_n, port_a_access_request_n} <= 3'h7;
		@(posedge clk);
	endtask

	task automatic b_acc(input logic [1:0] bk, input logic [3:0] hd);
		int n, g, r;
		logic bad;
		q.push_back({2'b11, bk});
		bank_b <= bk;
		hold_b <= hd;
		cse_n <= 1'b0;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		n = 0;
		g = -1;
		r = -1;
		bad = 1'b0;
		while (bdone !== 1'b1 && n < 120)
		begin
			@(posedge clk);
			n++;
			if (g < 0 && gnt === 1'b1)
				g = n;
			if (r >= 0 && ack_n !== 1'b0)
				bad = 1'b1;
			if (r < 0 && ack_n === 1'b0)
				r = n;
		end
		gap = r - g;
		chk(8'(bad), 8'h00);
		@(posedge clk);
		chk(8'({row, ack_n, col, gnt}), 8'h7d);
		cse_n <= 1'b1;
		@(posedge clk);
	endtask

	initial
	begin
		{cs_n, ads_n, port_a_access_request_n, lock_n, cse_n} = 5'h1f;
		{rst_n, rfq, psl, psh, go} = 5'h00;
		{bank_a, bank_b, hold_b} = 8'h01;
		row_prev = 4'hf;
		k = $urandom(32'ha39419db);
		repeat (2) @(posedge clk);
		chk(8'({gnt, row, ack_n, rfa, wt_n}), 8'h7d);
		rst_n <= 1'b1;
		@(posedge clk);
		$display("test reset done");
		a_acc(2'h0, 4'h3, 1'b0);
		a_acc(2'h1, 4'h2, 1'b1);
		repeat (4) @(posedge clk);
		chk(8'(gnt), 8'h00);
		$display("test port_a done");
		for (int s = 0; s < 4; s++)
		begin
			{psh, psl} <= 2'(s);
			a_acc(2'(s), 4'h1, 1'b0);
			b_acc(2'(s + 2), 4'h2);
			chk(8'(gap), 8'(1 + (s & 1)));
		end
		b_acc(2'h2, 4'h1);
		chk(lat, 8'h02);
		$display("test switch done");
		a_acc(2'h0, 4'h1, 1'b0);
		lock_n <= 1'b0;
		fork
			b_acc(2'h1, 4'h1);
			begin
				repeat (10) @(posedge clk);
				chk(8'({gnt, row}), 8'h0f);
				lock_n <= 1'b1;
			end
		join
		$display("test lock done");
		a_acc(2'h0, 4'h1, 1'b0);
		fork
			a_acc(2'h3, 4'h8, 1'b0);
			begin
				repeat (2) @(posedge clk);
				b_acc(2'h1, 4'h1);
			end
			begin
				repeat (8) @(posedge clk);
				chk(8'(gnt), 8'h00);
			end
		join
		$display("test hold done");
		fork
			b_acc(2'h2, 4'h1);
			begin
				@(posedge clk);
				rfq <= 1'b1;
				k = 0;
				do
				begin
					@(posedge clk);
					k++;
				end
				while (rfa !== 1'b1 && k < 40);
				chk(8'({rfa, row, ack_n}), 8'h21);
				rfq <= 1'b0;
			end
		join
		$display("test refresh done");
		for (int i = 0; i < 8; i++)
		begin
			k = $urandom;
			if (k[0])
				a_acc(2'(k >> 1), 4'(1 + k[4:3]), k[5]);
			else
				b_acc(2'(k >> 1), 4'(1 + k[4:3]));
		end
		chk(8'(q.size()), 8'h00);
		$display("test random done");
		end_of_test();
	end
endmodule

/* File: testbench/dva_cpu_b_model.sv */
`timescale 1ns/100ps
module dva_cpu_b_model
(
	input  wire logic       clk_sys_i,
	input  wire logic       go_i,
	input  wire logic [3:0] hold_i,
	input  wire logic       ack_n_i,
	output logic            req_n_o,
	output logic [7:0]      lat_o,
	output logic            done_o
);
	int n;

	initial
	begin
		req_n_o = 1'b1;
		lat_o = 8'h00;
		done_o = 1'b0;
		forever
		begin
			@(posedge clk_sys_i);
			done_o <= 1'b0;
			if (go_i === 1'b1)
			begin
				req_n_o <= 1'b0;
				n = 0;
				do
				begin
					@(posedge clk_sys_i);
					n++;
				end
				while (ack_n_i !== 1'b0 && n < 60);
				lat_o <= 8'(n);
				// The request stays low for the whole access.
				repeat (hold_i) @(posedge clk_sys_i);
				req_n_o <= 1'b1;
				done_o <= 1'b1;
			end
		end
	end
endmodule
